// ### dpzo_map.svh
`ifndef DPZO_MAP_SVH
`define DPZO_MAP_SVH
// Timing counts in clock cycles of the 20 MHz device clock
`define DPZO_CLK_PERIOD_NS   50
`define DPZO_TCKE_NS         5000
`define DPZO_TCKE_CYC        ((`DPZO_TCKE_NS + `DPZO_CLK_PERIOD_NS - 1) / `DPZO_CLK_PERIOD_NS)
`define DPZO_TXP_CYC         3
`define DPZO_TXPDLL_CYC      10
`define DPZO_TRFC_CYC        8
`define DPZO_TRP_CYC         3
`define DPZO_TXS_CYC         9
`define DPZO_TZQINIT_CYC     512
`define DPZO_TZQOPER_CYC     256
`define DPZO_TZQCS_CYC       64
// Mode register field positions
`define DPZO_MR1_RTT_A2      2
`define DPZO_MR1_RTT_A6      6
`define DPZO_MR1_RTT_A9      9
`define DPZO_MR1_TDQS_A11    11
`define DPZO_MR2_RTTWR_A9    9
`define DPZO_MR2_RTTWR_A10   10
// Controller register offsets
`define DPZO_REG_CMD         4'h0
`define DPZO_REG_STATUS      4'h1
`define DPZO_REG_MR1         4'h2
`define DPZO_REG_MR2         4'h3
`define DPZO_REG_STRAP       4'h4
// Command register bit positions
`define DPZO_CMD_PD_ENTER    0
`define DPZO_CMD_PD_EXIT     1
`define DPZO_CMD_REFRESH     2
`define DPZO_CMD_ZQCL        3
`define DPZO_CMD_ZQCS        4
`define DPZO_CMD_SR_ENTER    5
`define DPZO_CMD_SR_EXIT     6
`define DPZO_CMD_ODT         7
`define DPZO_CMD_PRECHARGE   8
`define DPZO_CMD_MRS         9
`endif

// ### dpzo_pkg.sv
package dpzo_pkg;
    // Command bus encoding seen by the device
    typedef enum logic [2:0] {
        DPZO_NOP  = 3'h0,
        DPZO_REF  = 3'h1,
        DPZO_ZQCL = 3'h2,
        DPZO_ZQCS = 3'h3,
        DPZO_PREA = 3'h4,
        DPZO_MRS1 = 3'h5,
        DPZO_MRS2 = 3'h6
    } dpzo_cmd_e;

    // Device operating state
    typedef enum logic [1:0] {
        DPZO_DEV_IDLE = 2'h0,
        DPZO_DEV_PD   = 2'h1,
        DPZO_DEV_SR   = 2'h2,
        DPZO_DEV_CAL  = 2'h3
    } dpzo_dev_e;

    // Controller sequencing state
    typedef enum logic [1:0] {
        DPZO_CTL_RUN  = 2'h0,
        DPZO_CTL_PD   = 2'h1,
        DPZO_CTL_SR   = 2'h2,
        DPZO_CTL_ZQ   = 2'h3
    } dpzo_ctl_e;
endpackage : dpzo_pkg

// ### dpzo_link_if.sv
`timescale 1ns/1ns
interface dpzo_link_if;
    logic                   cke;
    logic                   odt;
    dpzo_pkg::dpzo_cmd_e    cmd;
    logic [12:0]            addr;
    logic                   dq_oe;

    modport ctl (output cke, output odt, output cmd, output addr, input dq_oe);
    modport dev (input cke, input odt, input cmd, input addr, output dq_oe);
endinterface : dpzo_link_if

// ### dpzo_wait_cnt.sv
`timescale 1ns/1ns
// Down-counter; done while zero, reloads on start
module dpzo_wait_cnt #(
    parameter int W = 10
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // Control
    input  wire logic         start_i,
    input  wire logic [W-1:0] load_i,
    output logic              done_o
);
    logic [W-1:0] count;

    // Load wins over the running count
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count <= '0;
        end else if (start_i) begin
            count <= load_i;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign done_o = (count == '0);
endmodule : dpzo_wait_cnt

// ### dpzo_dev.sv
`timescale 1ns/1ns
`include "dpzo_map.svh"
// Device end: termination decision and calibration engine
module dpzo_dev #(
    parameter int ZQINIT_CYC = `DPZO_TZQINIT_CYC,
    parameter int ZQOPER_CYC = `DPZO_TZQOPER_CYC,
    parameter int ZQCS_CYC   = `DPZO_TZQCS_CYC
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Link
    dpzo_link_if.dev        link,
    // Status
    output logic            rtt_on_o,
    output logic            tdqs_term_o,
    output logic [4:0]      rtt_sel_o,
    output logic            cal_busy_o,
    output logic            zq_current_o,
    output logic            cal_done_o,
    output logic            in_self_ref_o
);
    logic [12:0] mr1;
    logic [12:0] mr2;
    logic        first_zqcl_done;
    logic        in_sr;
    logic        in_pd;
    logic        cke_q;
    logic [9:0]  cal_load;
    logic        cal_cnt_done;
    logic        cal_run;

    wire cmd_zqcl = link.cke && link.cmd == dpzo_pkg::DPZO_ZQCL;
    wire cmd_zqcs = link.cke && link.cmd == dpzo_pkg::DPZO_ZQCS;
    wire cal_go   = (cmd_zqcl || cmd_zqcs) && !in_sr && !cal_run;
    wire [2:0] rtt_nom = {mr1[`DPZO_MR1_RTT_A9], mr1[`DPZO_MR1_RTT_A6], mr1[`DPZO_MR1_RTT_A2]};
    wire [1:0] rtt_wr  = {mr2[`DPZO_MR2_RTTWR_A10], mr2[`DPZO_MR2_RTTWR_A9]};
    wire odt_enabled = (rtt_nom != 3'h0) || (rtt_wr != 2'h0);
    // Pin and mode bits, plus a refresh with falling CKE; no other command enters this term
    // Entry edge counts too, so termination never blips on the way in
    wire sr_entry = cke_q && !link.cke && link.cmd == dpzo_pkg::DPZO_REF;
    wire next_rtt = link.odt && odt_enabled && !in_sr && !sr_entry;

    // First long calibration gets the longer window; one less so done lands inside it
    assign cal_load = cmd_zqcs ? 10'(ZQCS_CYC - 1)
                    : (first_zqcl_done ? 10'(ZQOPER_CYC - 1) : 10'(ZQINIT_CYC - 1));

    dpzo_wait_cnt #(.W(10)) u_cal_cnt (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (cal_go),
        .load_i    (cal_load),
        .done_o    (cal_cnt_done)
    );

    // Mode registers, power state and calibration engine
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mr1             <= 13'h0000;
            mr2             <= 13'h0000;
            first_zqcl_done <= 1'b0;
            in_sr           <= 1'b0;
            in_pd           <= 1'b0;
            cke_q           <= 1'b1;
            cal_run         <= 1'b0;
            cal_done_o      <= 1'b0;
            rtt_on_o        <= 1'b0;
            tdqs_term_o     <= 1'b0;
            rtt_sel_o       <= 5'h00;
            cal_busy_o      <= 1'b0;
            zq_current_o    <= 1'b0;
            in_self_ref_o   <= 1'b0;
        end else begin
            cke_q <= link.cke;
            if (link.cke && link.cmd == dpzo_pkg::DPZO_MRS1) mr1 <= link.addr;
            if (link.cke && link.cmd == dpzo_pkg::DPZO_MRS2) mr2 <= link.addr;
            // Refresh with CKE falling is self-refresh; NOP with falling CKE is power-down
            if (cke_q && !link.cke) begin
                in_sr <= (link.cmd == dpzo_pkg::DPZO_REF);
                in_pd <= (link.cmd != dpzo_pkg::DPZO_REF);
            end else if (!cke_q && link.cke) begin
                in_sr <= 1'b0;
                in_pd <= 1'b0;
            end
            cal_done_o <= 1'b0;
            if (cal_go) begin
                cal_run <= 1'b1;
                if (cmd_zqcl) first_zqcl_done <= 1'b1;
            end else if (cal_run && cal_cnt_done) begin
                cal_run    <= 1'b0;
                cal_done_o <= 1'b1;                                  // copy results out
            end
            rtt_on_o      <= next_rtt;
            // TDQS pair follows termination only when enabled in MR1
            tdqs_term_o   <= next_rtt && mr1[`DPZO_MR1_TDQS_A11];
            rtt_sel_o     <= {rtt_wr, rtt_nom};
            cal_busy_o    <= cal_go || (cal_run && !cal_cnt_done);
            zq_current_o  <= cal_go || (cal_run && !cal_cnt_done);
            in_self_ref_o <= in_sr || sr_entry;
        end
    end

    // Never drive DQ here; bus kept quiet for calibration
    assign link.dq_oe = 1'b0;
endmodule : dpzo_dev

// ### dpzo_ctl.sv
`timescale 1ns/1ns
`include "dpzo_map.svh"
module dpzo_ctl #(
    parameter int TCKE_CYC   = `DPZO_TCKE_CYC,
    parameter int TXP_CYC    = `DPZO_TXP_CYC,
    parameter int TXPDLL_CYC = `DPZO_TXPDLL_CYC,
    parameter int TRFC_CYC   = `DPZO_TRFC_CYC,
    parameter int TRP_CYC    = `DPZO_TRP_CYC,
    parameter int TXS_CYC    = `DPZO_TXS_CYC,
    parameter int ZQINIT_CYC = `DPZO_TZQINIT_CYC,
    parameter int ZQOPER_CYC = `DPZO_TZQOPER_CYC,
    parameter int ZQCS_CYC   = `DPZO_TZQCS_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // Software port
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    // Shared calibration resistor arbitration
    input  wire logic        zq_grant_i,
    output logic             zq_req_o,
    // Link
    dpzo_link_if.ctl         link
);
    dpzo_pkg::dpzo_ctl_e state;
    dpzo_pkg::dpzo_ctl_e next_state;
    logic [9:0]  pending;
    logic [12:0] mr1_val;
    logic [12:0] mr2_val;
    logic        wdata_mrs_sel;
    logic        odt_want;
    logic        first_zqcl_done;
    logic        low_in_trfc;
    logic        cal_is_long;
    logic [9:0]  load;
    logic        cnt_done;
    logic        start;
    logic [9:0]  cnt_cke;
    logic [9:0]  cnt_xp;
    logic [9:0]  cnt_xpdll;
    logic [9:0]  cnt_rfc;
    logic [9:0]  cnt_rp;
    logic [9:0]  cnt_xs;
    dpzo_pkg::dpzo_cmd_e next_cmd;
    logic [12:0] next_addr;

    // Saturating decrement used for every timing counter except the calibration one in u_zq_cnt
    function automatic logic [9:0] dec_sat(input logic [9:0] v);
        dec_sat = (v == 10'h000) ? 10'h000 : v - 10'h001;
    endfunction : dec_sat

    wire wr_cmd   = wr_i && addr_i == `DPZO_REG_CMD;
    wire req_pde  = pending[`DPZO_CMD_PD_ENTER];
    wire req_pdx  = pending[`DPZO_CMD_PD_EXIT];
    wire req_ref  = pending[`DPZO_CMD_REFRESH];
    wire req_zql  = pending[`DPZO_CMD_ZQCL];
    wire req_zqs  = pending[`DPZO_CMD_ZQCS];
    wire req_sre  = pending[`DPZO_CMD_SR_ENTER];
    wire req_srx  = pending[`DPZO_CMD_SR_EXIT];
    wire req_pre  = pending[`DPZO_CMD_PRECHARGE];
    wire req_mrs  = pending[`DPZO_CMD_MRS];
    wire run      = state == dpzo_pkg::DPZO_CTL_RUN;
    // CKE may drop only when tXPDLL met and no earlier drop inside tRFC
    wire may_drop = cnt_xpdll == 10'h000 && !low_in_trfc && cnt_rp == 10'h000;
    wire do_pde   = run && req_pde && may_drop;
    wire do_sre   = run && req_sre && may_drop && cnt_xp == 10'h000;
    wire do_pdx   = state == dpzo_pkg::DPZO_CTL_PD && req_pdx && cnt_cke == 10'h000;
    wire do_srx   = state == dpzo_pkg::DPZO_CTL_SR && req_srx && cnt_cke == 10'h000;
    // Refresh only once tXP and tRFC from the last refresh have passed
    wire do_ref   = run && req_ref && !req_sre && cnt_xp == 10'h000
                    && cnt_rfc == 10'h000 && cnt_xs == 10'h000;
    wire do_pre   = run && req_pre && cnt_xp == 10'h000 && cnt_rfc == 10'h000;
    wire do_mrs   = run && req_mrs && cnt_rp == 10'h000 && cnt_rfc == 10'h000 && cnt_xp == 10'h000;
    // Calibration needs tRP, tXS, tXP, tRFC and the shared resistor, but no precharge
    wire zq_ready = run && (req_zql || req_zqs) && cnt_rp == 10'h000 && cnt_xs == 10'h000
                    && cnt_xp == 10'h000 && cnt_rfc == 10'h000;
    wire do_zq    = zq_ready && zq_grant_i;
    // Pin may stay up in self-refresh, where the device ignores it anyway
    wire odt_ok   = next_state == dpzo_pkg::DPZO_CTL_RUN || next_state == dpzo_pkg::DPZO_CTL_SR;

    assign cal_is_long = req_zql;
    assign load = cal_is_long ? (first_zqcl_done ? 10'(ZQOPER_CYC) : 10'(ZQINIT_CYC))
                              : 10'(ZQCS_CYC);
    assign start = do_zq;

    dpzo_wait_cnt #(.W(10)) u_zq_cnt (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (start),
        .load_i    (load),
        .done_o    (cnt_done)
    );

    // Next state and command selection
    always_comb begin
        next_state = state;
        next_cmd   = dpzo_pkg::DPZO_NOP;
        next_addr  = 13'h0000;
        unique case (state)
            dpzo_pkg::DPZO_CTL_RUN: begin
                if (do_zq) begin
                    next_state = dpzo_pkg::DPZO_CTL_ZQ;
                    next_cmd   = req_zql ? dpzo_pkg::DPZO_ZQCL : dpzo_pkg::DPZO_ZQCS;
                end else if (do_sre) begin
                    next_state = dpzo_pkg::DPZO_CTL_SR;
                    next_cmd   = dpzo_pkg::DPZO_REF;
                end else if (do_pde) begin
                    next_state = dpzo_pkg::DPZO_CTL_PD;
                end else if (do_ref) begin
                    next_cmd   = dpzo_pkg::DPZO_REF;
                end else if (do_pre) begin
                    next_cmd   = dpzo_pkg::DPZO_PREA;
                end else if (do_mrs) begin
                    next_cmd   = wdata_mrs_sel ? dpzo_pkg::DPZO_MRS2 : dpzo_pkg::DPZO_MRS1;
                    next_addr  = wdata_mrs_sel ? mr2_val : mr1_val;
                end
            end
            dpzo_pkg::DPZO_CTL_PD: if (do_pdx) next_state = dpzo_pkg::DPZO_CTL_RUN;
            dpzo_pkg::DPZO_CTL_SR: if (do_srx) next_state = dpzo_pkg::DPZO_CTL_RUN;
            dpzo_pkg::DPZO_CTL_ZQ: if (cnt_done && !start) next_state = dpzo_pkg::DPZO_CTL_RUN;
        endcase
    end

    // Requests, timers and pins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state           <= dpzo_pkg::DPZO_CTL_RUN;
            pending         <= 10'h000;
            odt_want        <= 1'b0;
            first_zqcl_done <= 1'b0;
            low_in_trfc     <= 1'b0;
            mr1_val         <= 13'h0000;
            mr2_val         <= 13'h0000;
            wdata_mrs_sel   <= 1'b0;
            cnt_cke         <= 10'h000;
            cnt_xp          <= 10'h000;
            cnt_xpdll       <= 10'h000;
            cnt_rfc         <= 10'h000;
            cnt_rp          <= 10'h000;
            cnt_xs          <= 10'h000;
            rdata_o         <= 16'h0000;
            zq_req_o        <= 1'b0;
            link.cke        <= 1'b1;
            link.odt        <= 1'b0;
            link.cmd        <= dpzo_pkg::DPZO_NOP;
            link.addr       <= 13'h0000;
        end else begin
            state     <= next_state;
            link.cmd  <= next_cmd;
            link.addr <= next_addr;
            // New request bits win over completion clears
            pending <= (pending & ~{do_mrs, do_pre, 1'b0, do_srx, do_sre, do_zq && req_zqs && !req_zql,
                        do_zq && req_zql, do_ref, do_pdx, do_pde})
                       | (wr_cmd ? {wdata_i[9:8], 1'b0, wdata_i[6:0]} : 10'h000);
            if (wr_cmd) odt_want <= wdata_i[`DPZO_CMD_ODT];
            if (wr_i && addr_i == `DPZO_REG_MR1) begin
                mr1_val <= wdata_i[12:0];
            end
            if (wr_i && addr_i == `DPZO_REG_MR2) begin
                mr2_val <= wdata_i[12:0];
            end
            if (wr_i && addr_i == `DPZO_REG_STRAP) wdata_mrs_sel <= wdata_i[0];
            if (do_zq && req_zql) first_zqcl_done <= 1'b1;
            // CKE low while in PD or SR; high throughout calibration
            link.cke <= !(next_state == dpzo_pkg::DPZO_CTL_PD || next_state == dpzo_pkg::DPZO_CTL_SR);
            link.odt <= odt_want && odt_ok && !do_zq;
            zq_req_o <= zq_ready || state == dpzo_pkg::DPZO_CTL_ZQ;
            cnt_cke   <= (do_pde || do_sre || do_pdx || do_srx) ? 10'(TCKE_CYC) : dec_sat(cnt_cke);
            cnt_xp    <= do_pdx ? 10'(TXP_CYC) : dec_sat(cnt_xp);
            cnt_xpdll <= do_pdx ? 10'(TXPDLL_CYC) : dec_sat(cnt_xpdll);
            cnt_rfc   <= (do_ref || do_sre) ? 10'(TRFC_CYC) : dec_sat(cnt_rfc);
            cnt_rp    <= do_pre ? 10'(TRP_CYC) : dec_sat(cnt_rp);
            cnt_xs    <= do_srx ? 10'(TXS_CYC) : dec_sat(cnt_xs);
            // Track refresh windows so CKE drops only once per tRFC
            if (do_ref) begin
                low_in_trfc <= 1'b0;
            end else if (cnt_rfc == 10'h001) begin
                low_in_trfc <= 1'b0;
            end else if (do_pde && cnt_rfc != 10'h000) begin
                low_in_trfc <= 1'b1;
            end
            rdata_o <= 16'h0000;
            if (rd_i && addr_i == `DPZO_REG_STATUS) begin
                rdata_o <= {12'h000, first_zqcl_done, 1'b0, state};
            end else if (rd_i && addr_i == `DPZO_REG_CMD) begin
                rdata_o <= {6'h00, pending};
            end else if (rd_i && addr_i == `DPZO_REG_MR1) begin
                rdata_o <= {3'h0, mr1_val};
            end else if (rd_i && addr_i == `DPZO_REG_MR2) begin
                rdata_o <= {3'h0, mr2_val};
            end
        end
    end
endmodule : dpzo_ctl

// ### dpzo_sva.sv
`timescale 1ns/1ns
// Protocol watch on the controller side of the link
module dpzo_sva #(
    parameter int TCKE   = 4,
    parameter int TXP    = 3,
    parameter int TXPDLL = 10,
    parameter int TRFC   = 8,
    parameter int TRP    = 3,
    parameter int ZQINIT = 40,
    parameter int ZQOPER = 20,
    parameter int ZQCS   = 10
) (
    // Clock and reset
    input wire logic                clk_i,
    input wire logic                sys_rst_i,
    // Link
    input wire logic                cke,
    input wire logic                odt,
    input wire dpzo_pkg::dpzo_cmd_e cmd,
    input wire logic [12:0]         addr,
    input wire logic                dq_oe
);
    logic [9:0] low_cnt, hi_cnt, ref_cnt, pre_cnt, zq_left;
    logic       cke_q, fell_seen, zq_first;
    wire logic  is_zq = (cmd == dpzo_pkg::DPZO_ZQCL) || (cmd == dpzo_pkg::DPZO_ZQCS);
    wire logic  fall  = cke_q & ~cke;

    // Counters saturate, so reset reads as long ago
    always_ff @(posedge clk_i) begin
        cke_q   <= sys_rst_i | cke;
        low_cnt <= (sys_rst_i || cke) ? 10'h000 : low_cnt + {9'h000, ~&low_cnt};
        hi_cnt  <= sys_rst_i ? 10'h3ff : (!cke ? 10'h000 : hi_cnt + {9'h000, ~&hi_cnt});
    end

    // Refresh window and precharge age
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || cmd == dpzo_pkg::DPZO_REF) begin
            ref_cnt   <= sys_rst_i ? 10'h3ff : 10'h001;
            fell_seen <= 1'b0;
        end else begin
            ref_cnt   <= ref_cnt + {9'h000, ~&ref_cnt};
            fell_seen <= fell_seen | (fall & (ref_cnt < TRFC));
        end
        pre_cnt <= sys_rst_i ? 10'h000 : (cmd == dpzo_pkg::DPZO_PREA) ? 10'h001
                   : pre_cnt + {9'h000, (pre_cnt != 10'h000) & ~&pre_cnt};
    end

    // Calibration window, one cycle short to allow for either count origin
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            zq_left  <= 10'h000;
            zq_first <= 1'b1;
        end else if (is_zq) begin
            zq_left  <= (cmd == dpzo_pkg::DPZO_ZQCS) ? 10'(ZQCS - 1)
                        : zq_first ? 10'(ZQINIT - 1) : 10'(ZQOPER - 1);
            zq_first <= zq_first & (cmd != dpzo_pkg::DPZO_ZQCL);
        end else if (zq_left != 10'h000) begin
            zq_left  <= zq_left - 10'h001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_pd_min_hold: assert property ($rose(cke) |-> low_cnt >= TCKE)
        else $error("power-down exit too soon");
    a_ref_after_exit: assert property ((cmd == dpzo_pkg::DPZO_REF && cke) |-> hi_cnt >= TXP)
        else $error("refresh too soon after exit");
    a_pd_reentry_wait: assert property ($fell(cke) |-> hi_cnt >= TXPDLL)
        else $error("power-down re-entered too soon");
    a_one_low_trfc: assert property ((fall && ref_cnt < TRFC) |-> !fell_seen)
        else $error("second cke low inside refresh window");
    a_zq_cke_high: assert property ((zq_left != 10'h000) |-> cke)
        else $error("cke low during calibration");
    a_zq_odt_low: assert property ((zq_left != 10'h000) |-> !odt)
        else $error("odt high during calibration");
    a_zq_quiet_bus: assert property ((zq_left != 10'h000) |-> cmd == dpzo_pkg::DPZO_NOP)
        else $error("command during calibration");
    a_zq_after_pre: assert property (is_zq |-> pre_cnt >= TRP)
        else $error("calibration without precharge");
    a_dq_hiz: assert property (is_zq |=> !dq_oe [*8])
        else $error("data bus driven during calibration");
endmodule : dpzo_sva

// ### tb.sv
`timescale 1ns/1ns
`include "dpzo_map.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    localparam int TCKE = 4, TXP = 3, TXPDLL = 10, TRFC = 24, TRP = 3, TXS = 30;
    localparam int ZQI = 40, ZQO = 20, ZQS = 10;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, zq_grant_i = 1'b1;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000, rdata_o;
    logic        zq_req_o, rtt_on_o, tdqs_term_o, cal_busy_o, zq_current_o, cal_done_o, in_self_ref_o;
    logic [4:0]  rtt_sel_o;
    int          n_fail = 0, samples_checked = 0, cyc = 0, n;

    dpzo_link_if dpzo_link_if_i ();
    dpzo_ctl #(.TCKE_CYC(TCKE), .TXP_CYC(TXP), .TXPDLL_CYC(TXPDLL), .TRFC_CYC(TRFC), .TRP_CYC(TRP),
        .TXS_CYC(TXS), .ZQINIT_CYC(ZQI), .ZQOPER_CYC(ZQO), .ZQCS_CYC(ZQS)) dpzo_ctl_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .zq_grant_i(zq_grant_i), .zq_req_o(zq_req_o),
        .link(dpzo_link_if_i));
    dpzo_dev #(.ZQINIT_CYC(ZQI), .ZQOPER_CYC(ZQO), .ZQCS_CYC(ZQS)) dpzo_dev_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link(dpzo_link_if_i), .rtt_on_o(rtt_on_o),
        .tdqs_term_o(tdqs_term_o), .rtt_sel_o(rtt_sel_o), .cal_busy_o(cal_busy_o),
        .zq_current_o(zq_current_o), .cal_done_o(cal_done_o), .in_self_ref_o(in_self_ref_o));
    dpzo_sva #(.TCKE(TCKE), .TXP(TXP), .TXPDLL(TXPDLL), .TRFC(TRFC), .TRP(TRP), .ZQINIT(ZQI),
        .ZQOPER(ZQO), .ZQCS(ZQS)) dpzo_sva_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cke(dpzo_link_if_i.cke), .odt(dpzo_link_if_i.odt),
        .cmd(dpzo_link_if_i.cmd), .addr(dpzo_link_if_i.addr), .dq_oe(dpzo_link_if_i.dq_oe));

    // Clock and hang guard
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        `CHK(rdata_o, exp)
    endtask : rd

    // Index 8 and up selects a command code
    function automatic logic pick(input int k);
        case (k)
            0:       pick = dpzo_link_if_i.cke;
            1:       pick = dpzo_link_if_i.odt;
            2:       pick = in_self_ref_o;
            3:       pick = cal_done_o;
            4:       pick = zq_req_o;
            default: pick = (int'(dpzo_link_if_i.cmd) == k - 8);
        endcase
    endfunction : pick

    // Bounded poll, one look per cycle so pulses are not missed
    task automatic wait_sig(input int k, input logic v);
        #1;
        n = 0;
        while (pick(k) !== v && n < 600) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 600) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, pick(k), v);
        end
    endtask : wait_sig

    task automatic term_case(input logic s, input logic [3:0] a, input logic [15:0] v, input logic [6:0] e);
        wr(`DPZO_REG_STRAP, {15'h0000, s});
        wr(a, v);
        wr(`DPZO_REG_CMD, 16'h0200);
        wait_sig(s ? 14 : 13, 1'b1);
        wr(`DPZO_REG_CMD, 16'h0080);
        wait_sig(1, 1'b1);
        @(posedge clk_i);
        #1;
        `CHK({rtt_on_o, tdqs_term_o, rtt_sel_o}, e)
        rd(4'hf, 16'h0000);
        `CHK(rtt_on_o, e[6])
        wr(`DPZO_REG_CMD, 16'h0000);
        wait_sig(1, 1'b0);
        @(posedge clk_i);
        #1;
        `CHK(rtt_on_o, 1'b0)
    endtask : term_case

    task automatic t_term();
        term_case(1'b0, `DPZO_REG_MR1, 16'h0a44, 7'h67);
        term_case(1'b0, `DPZO_REG_MR1, 16'h0040, 7'h42);
        term_case(1'b0, `DPZO_REG_MR1, 16'h0000, 7'h00);
        term_case(1'b1, `DPZO_REG_MR2, 16'h0600, 7'h58);
        term_case(1'b1, `DPZO_REG_MR2, 16'h0000, 7'h00);
    endtask : t_term

    task automatic zq_run(input int k, input int win);
        wait_sig(k, 1'b1);
        @(posedge clk_i);
        #1;
        `CHK(zq_current_o, 1'b1)
        wait_sig(3, 1'b1);
        `CHK(n <= win, 1'b1)
        @(posedge clk_i);
        #1;
        `CHK({cal_busy_o, zq_current_o}, 2'b00)
        wait_sig(4, 1'b0);
    endtask : zq_run

    // Resistor held back first, so the controller must wait for it
    task automatic t_zq();
        @(posedge clk_i);
        zq_grant_i <= 1'b0;
        wr(`DPZO_REG_CMD, 16'h0100);
        wr(`DPZO_REG_CMD, 16'h0008);
        wait_sig(4, 1'b1);
        repeat (20) begin
            @(posedge clk_i);
            #1;
            `CHK(cal_busy_o, 1'b0)
        end
        @(posedge clk_i);
        zq_grant_i <= 1'b1;
        zq_run(10, ZQI);
        rd(`DPZO_REG_STATUS, 16'h0008);
        wr(`DPZO_REG_CMD, 16'h0100);
        wr(`DPZO_REG_CMD, 16'h0008);
        zq_run(10, ZQO);
        wr(`DPZO_REG_CMD, 16'h0100);
        wr(`DPZO_REG_CMD, 16'h0010);
        zq_run(11, ZQS);
    endtask : t_zq

    // Exit requested at once, then refresh and entry back to back
    task automatic t_pd();
        int t0, tx, tr;
        wr(`DPZO_REG_CMD, 16'h0001);
        wait_sig(0, 1'b0);
        t0 = cyc;
        rd(`DPZO_REG_STATUS, 16'h0009);
        wr(`DPZO_REG_CMD, 16'h0002);
        wait_sig(0, 1'b1);
        tx = cyc;
        `CHK(tx - t0 >= TCKE, 1'b1)
        wr(`DPZO_REG_CMD, 16'h0004);
        wr(`DPZO_REG_CMD, 16'h0001);
        wait_sig(9, 1'b1);
        tr = cyc;
        `CHK(tr - tx >= TXP, 1'b1)
        wait_sig(0, 1'b0);
        `CHK(cyc - tx >= TXPDLL, 1'b1)
        wr(`DPZO_REG_CMD, 16'h0002);
        wait_sig(0, 1'b1);
        wr(`DPZO_REG_CMD, 16'h0001);
        wait_sig(0, 1'b0);
        `CHK(cyc - tr >= TRFC, 1'b1)
        wr(`DPZO_REG_CMD, 16'h0002);
        wait_sig(0, 1'b1);
    endtask : t_pd

    task automatic t_sr();
        int t0;
        wr(`DPZO_REG_STRAP, 16'h0000);
        wr(`DPZO_REG_MR1, 16'h0004);
        wr(`DPZO_REG_CMD, 16'h0200);
        wait_sig(13, 1'b1);
        wr(`DPZO_REG_CMD, 16'h00a0);
        wait_sig(2, 1'b1);
        @(posedge clk_i);
        #1;
        `CHK({rtt_on_o, dpzo_link_if_i.cke, dpzo_link_if_i.odt}, 3'b001)
        rd(`DPZO_REG_STATUS, 16'h000a);
        wr(`DPZO_REG_CMD, 16'h0040);
        wait_sig(0, 1'b1);
        t0 = cyc;
        repeat (2) begin
            @(posedge clk_i);
            #1;
            `CHK(cal_busy_o, 1'b0)
        end
        wr(`DPZO_REG_CMD, 16'h0100);
        wr(`DPZO_REG_CMD, 16'h0010);
        wait_sig(11, 1'b1);
        `CHK(cyc - t0 >= TXS, 1'b1)
        `CHK(cal_busy_o, 1'b0)
        wait_sig(3, 1'b1);
    endtask : t_sr

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        `CHK({dpzo_link_if_i.cke, dpzo_link_if_i.odt, dpzo_link_if_i.dq_oe}, 3'b100)
        t_term();
        t_zq();
        t_pd();
        t_sr();
        results();
    end
endmodule : tb
